// File: logic/mpu_region_select_base_regs.sv
`timescale 1ns/1ns
module mpu_region_select_base_regs
    import mpu_regs_pkg::*;
#(
    parameter int KERNEL_REGIONS  = 16,
    parameter int HYP_REGIONS     = 16,
    parameter bit HYP_IMPLEMENTED = 1'b1
) (
    input  wire logic                        mclk,
    input  wire logic                        reset,
    input  wire logic                        cp_req,
    input  wire logic                        cp_write,
    input  wire logic [3:0]                  cp_coproc,
    input  wire logic [2:0]                  cp_opc1,
    input  wire logic [3:0]                  cp_crn,
    input  wire logic [3:0]                  cp_crm,
    input  wire logic [2:0]                  cp_opc2,
    input  wire logic [31:0]                 cp_wdata,
    input  wire logic [1:0]                  cp_level,
    input  wire logic                        trap_general_exceptions_control,
    input  wire logic                        hyp_group_zero_trap,
    input  wire logic                        hyp_group_six_trap,
    input  wire logic                        hyp_group_ten_trap,
    input  wire logic                        virtual_memory_write_trap,
    input  wire logic                        virtual_memory_read_trap,
    input  wire logic                        identification_group_one_trap,
    input  wire logic [7:0]                  kernel_region_selector,
    output logic                             cp_done,
    output logic      [31:0]                 cp_rdata,
    output logic                             cp_trap,
    output logic                             cp_undefined,
    output logic      [7:0]                  hyp_region_selector,
    output logic      [KERNEL_REGIONS*32-1:0] region_base_attr
);
    import mpu_regs_pkg::*;

    // ------------------------------------------------------------
    // Derived widths
    // ------------------------------------------------------------
    localparam int HSEL_W = (HYP_REGIONS > 1) ? $clog2(HYP_REGIONS) : 1; // RULE_03
    localparam int KSEL_W = (KERNEL_REGIONS > 1) ? $clog2(KERNEL_REGIONS) : 1;
    localparam logic [7:0] KERNEL_COUNT = 8'(KERNEL_REGIONS);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic       is_sys;
    logic       hit_hsel;
    logic       hit_type;
    logic       hit_sel_base;
    logic       idx_shape;
    logic [4:0] idx_n;
    logic       idx_in_range;
    logic       hit_idx_base;
    logic       ksel_in_range;
    logic       is_kernel;

    assign is_sys   = (cp_coproc == COPROC_SYS);
    assign is_kernel = (cp_level == LEVEL_KERNEL);

    assign hit_hsel = is_sys && cp_opc1 == HSEL_OPC1 && cp_crn == HSEL_CRN
                      && cp_crm == HSEL_CRM && cp_opc2 == HSEL_OPC2; // RULE_06

    assign hit_type = is_sys && cp_opc1 == TYPE_OPC1 && cp_crn == TYPE_CRN
                      && cp_crm == TYPE_CRM && cp_opc2 == TYPE_OPC2; // RULE_10

    assign hit_sel_base = is_sys && cp_opc1 == BASE_OPC1 && cp_crn == BASE_CRN
                          && cp_crm == BASE_CRM && cp_opc2 == BASE_OPC2; // RULE_17

    // Direct index scattered over opc1, CRm and opc2
    assign idx_shape = is_sys && cp_opc1[2:1] == 2'h0 && cp_crn == BASE_CRN
                       && cp_crm[3] && cp_opc2[1:0] == 2'h0; // RULE_20
    assign idx_n        = {cp_opc1[0], cp_crm[2:0], cp_opc2[2]}; // RULE_20
    assign idx_in_range = (int'(idx_n) < KERNEL_REGIONS)
                          && (int'(idx_n) < DIRECT_COUNT); // RULE_19
    // Unimplemented indices fall through as unallocated encodings
    assign hit_idx_base = idx_shape && idx_in_range; // RULE_20

    assign ksel_in_range = int'(kernel_region_selector) < KERNEL_REGIONS; // RULE_12

    // ------------------------------------------------------------
    // Access permission and trap resolution
    // ------------------------------------------------------------
    logic next_trap;
    logic next_undef;
    logic allowed;
    logic base_group_trap;

    assign base_group_trap = hit_idx_base ? hyp_group_ten_trap : hyp_group_six_trap;

    always_comb begin
        next_trap  = 1'b0;
        next_undef = 1'b0;
        allowed    = 1'b0;
        if (!(hit_hsel || hit_type || hit_sel_base || hit_idx_base)) begin
            next_undef = 1'b1;
        end else if (cp_level == LEVEL_USER) begin
            next_undef = 1'b1; // RULE_06
        end else if (is_kernel && trap_general_exceptions_control) begin
            // Kernel level does not run while general traps route to hypervisor
            next_undef = 1'b1;
        end else if (hit_hsel) begin
            if (!is_kernel) begin
                allowed = 1'b1; // RULE_06
            end else if (HYP_IMPLEMENTED && hyp_group_six_trap) begin
                next_trap = 1'b1; // RULE_07
            end else begin
                next_undef = 1'b1; // RULE_06
            end
        end else if (hit_type) begin
            if (is_kernel && HYP_IMPLEMENTED && !cp_write
                && (hyp_group_zero_trap || identification_group_one_trap)) begin
                next_trap = 1'b1; // RULE_11
            end else begin
                allowed = 1'b1; // RULE_10
            end
        end else begin
            if (is_kernel && HYP_IMPLEMENTED
                && ((cp_write && virtual_memory_write_trap)
                    || (!cp_write && virtual_memory_read_trap)
                    || base_group_trap)) begin
                next_trap = 1'b1; // RULE_18
            end else begin
                allowed = 1'b1; // RULE_17
            end
        end
    end

    logic do_write;
    logic do_read;

    assign do_write = cp_req && allowed && cp_write;
    assign do_read  = cp_req && allowed && !cp_write;

    // ------------------------------------------------------------
    // Hypervisor region selector
    // ------------------------------------------------------------
    logic [HSEL_W-1:0] hsel_region;

    // Upper bits of an oversized value are dropped; software keeps it in range
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hsel_region <= SEL_RESET[HSEL_W-1:0]; // RULE_16
        end else if (do_write && hit_hsel) begin
            hsel_region <= cp_wdata[HSEL_W-1:0]; // RULE_05
        end
    end

    assign hyp_region_selector = 8'(hsel_region); // RULE_01

    // ------------------------------------------------------------
    // Region base storage
    // ------------------------------------------------------------
    logic [KERNEL_REGIONS-1:0] region_wr;
    logic [31:0]               region_word [KERNEL_REGIONS];

    genvar gi;
    generate
        for (gi = 0; gi < KERNEL_REGIONS; gi++) begin : g_region // RULE_04
            // Indirect and direct paths share one store per region
            assign region_wr[gi] = do_write
                && ((hit_sel_base && ksel_in_range
                     && int'(kernel_region_selector) == gi) // RULE_12
                    || (hit_idx_base && int'(idx_n) == gi)); // RULE_19

            region_base_store u_store (
                .mclk       (mclk),
                .reset      (reset),
                .write_en   (region_wr[gi]),
                .write_data (cp_wdata),
                .value      (region_word[gi])
            );

            assign region_base_attr[gi*32 +: 32] = region_word[gi]; // RULE_21
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    logic [31:0] read_word;

    always_comb begin
        read_word = WORD_ZERO;
        if (hit_hsel) begin
            read_word = 32'(hsel_region); // RULE_02
        end else if (hit_type) begin
            // Bit zero stays clear: no separate instruction and data regions
            read_word = WORD_ZERO;
            read_word[TYPE_COUNT_MSB:TYPE_COUNT_LSB] = KERNEL_COUNT; // RULE_08
            read_word[0] = 1'b0; // RULE_09
        end else if (hit_sel_base) begin
            // Out-of-range kernel selector reads as zero
            if (ksel_in_range) begin
                read_word = region_word[kernel_region_selector[KSEL_W-1:0]]; // RULE_12
            end
        end else if (hit_idx_base) begin
            read_word = region_word[idx_n[KSEL_W-1:0]]; // RULE_19
        end
    end

    // ------------------------------------------------------------
    // Response
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cp_done <= 1'b0;
        end else begin
            cp_done <= cp_req;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cp_trap      <= 1'b0;
            cp_undefined <= 1'b0;
        end else begin
            cp_trap      <= cp_req && next_trap;
            cp_undefined <= cp_req && next_undef;
        end
    end

    // Read data held until the next allowed read so it can be sampled late
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cp_rdata <= WORD_ZERO;
        end else if (do_read) begin
            cp_rdata <= read_word;
        end
    end

endmodule : mpu_region_select_base_regs

// File: shared/mpu_regs_pkg.sv
// Function
// RULE_01 - Hypervisor selector picks the region used by hypervisor base and limit registers
// RULE_02 - Selector region number in low byte, zero-extended, upper bits read zero
// RULE_03 - Stored selector width is ceiling of log2 of hypervisor region count
// RULE_04 - Regions are numbered zero upward by one to count minus one
// RULE_05 - Software never writes a selector value at or above region count
// RULE_06 - Selector reached only from hypervisor level at encoding 4, c6, c2, 1
// RULE_07 - Kernel access to selector traps when group six trap set
// RULE_08 - Type register reports kernel region count in bits 15:8, rest zero
// RULE_09 - Regions are unified only; type bit zero reads zero
// RULE_10 - Type register at encoding 0, c0, c0, 4 from kernel or hypervisor
// RULE_11 - Kernel type reads trap on group zero trap or identification trap
// RULE_12 - Indirect base register accesses region named by kernel region selector
// RULE_13 - Base bits 31:6 form inclusive lower address; bit 5 reads zero
// RULE_14 - Shareability in bits 4:3; code 01 reserved
// RULE_15 - Permission in bits 2:1, execute-never in bit 0
// RULE_16 - Base, attribute and selector fields have no meaningful reset value
// RULE_17 - Indirect base at encoding 0, c6, c3, 0 from kernel or hypervisor
// RULE_18 - Kernel base writes trap on write trap, reads on read trap, all on group trap
// RULE_19 - Directly indexed base registers for first 32 kernel regions, same layout
// RULE_20 - Direct register n decodes from opc1, CRm, opc2 bits; unimplemented n unallocated
// RULE_21 - Base and attributes of every region presented to address checking logic
package mpu_regs_pkg;

    // ------------------------------------------------------------
    // Access encodings
    // ------------------------------------------------------------
    localparam logic [3:0] COPROC_SYS     = 4'hF;
    localparam logic [2:0] HSEL_OPC1      = 3'h4;
    localparam logic [3:0] HSEL_CRN       = 4'h6;
    localparam logic [3:0] HSEL_CRM       = 4'h2;
    localparam logic [2:0] HSEL_OPC2      = 3'h1;
    localparam logic [2:0] TYPE_OPC1      = 3'h0;
    localparam logic [3:0] TYPE_CRN       = 4'h0;
    localparam logic [3:0] TYPE_CRM       = 4'h0;
    localparam logic [2:0] TYPE_OPC2      = 3'h4;
    localparam logic [2:0] BASE_OPC1      = 3'h0;
    localparam logic [3:0] BASE_CRN       = 4'h6;
    localparam logic [3:0] BASE_CRM       = 4'h3;
    localparam logic [2:0] BASE_OPC2      = 3'h0;
    localparam int         DIRECT_COUNT   = 32;

    // ------------------------------------------------------------
    // Privilege level codes
    // ------------------------------------------------------------
    localparam logic [1:0] LEVEL_USER     = 2'h0;
    localparam logic [1:0] LEVEL_KERNEL   = 2'h1;
    localparam logic [1:0] LEVEL_HYP      = 2'h2;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int SEL_MSB        = 7;
    localparam int TYPE_COUNT_LSB = 8;
    localparam int TYPE_COUNT_MSB = 15;
    localparam int BASE_LSB       = 6;
    localparam int BASE_RSVD_BIT  = 5;
    localparam int SHARE_LSB      = 3;
    localparam int SHARE_MSB      = 4;
    localparam int PERM_LSB       = 1;
    localparam int PERM_MSB       = 2;
    localparam int EXEC_NEVER_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [25:0] BASE_RESET = 26'h0;
    localparam logic [1:0]  SHARE_RESET      = 2'h0;
    localparam logic [1:0]  PERM_RESET       = 2'h0;
    localparam logic        EXEC_NEVER_RESET = 1'b0;
    localparam logic [7:0]  SEL_RESET  = 8'h00;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

endpackage : mpu_regs_pkg

// File: logic/region_base_store.sv
`timescale 1ns/1ns
module region_base_store
    import mpu_regs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        write_en,
    input  wire logic [31:0] write_data,
    output logic      [31:0] value
);
    import mpu_regs_pkg::*;

    logic [25:0] base;
    logic [1:0]  shareability_field;
    logic [1:0]  permission_field;
    logic        execute_never_bit;

    // Defined reset only for determinism; software must program a region
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            base               <= BASE_RESET; // RULE_16
            shareability_field <= SHARE_RESET;
            permission_field   <= PERM_RESET;
            execute_never_bit  <= EXEC_NEVER_RESET;
        end else if (write_en) begin
            base               <= write_data[31:BASE_LSB]; // RULE_13
            shareability_field <= write_data[SHARE_MSB:SHARE_LSB]; // RULE_14
            permission_field   <= write_data[PERM_MSB:PERM_LSB]; // RULE_15
            execute_never_bit  <= write_data[EXEC_NEVER_BIT]; // RULE_15
        end
    end

    // Reserved shareability code kept as written, not corrected
    assign value = {base, 1'b0, shareability_field, permission_field, execute_never_bit}; // RULE_13

endmodule : region_base_store

// File: tb/region_access_checker.sv
`timescale 1ns/1ns
module region_access_checker
    import mpu_regs_pkg::*;
#(
    parameter int KERNEL_REGIONS  = 16,
    parameter int HYP_REGIONS     = 16,
    parameter bit HYP_IMPLEMENTED = 1'b1
) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        cp_req,
    input wire logic        cp_write,
    input wire logic [3:0]  cp_coproc,
    input wire logic [2:0]  cp_opc1,
    input wire logic [3:0]  cp_crn,
    input wire logic [3:0]  cp_crm,
    input wire logic [2:0]  cp_opc2,
    input wire logic [31:0] cp_wdata,
    input wire logic [1:0]  cp_level,
    input wire logic        trap_general_exceptions_control,
    input wire logic        hyp_group_zero_trap,
    input wire logic        hyp_group_six_trap,
    input wire logic        virtual_memory_write_trap,
    input wire logic        identification_group_one_trap,
    input wire logic        cp_done,
    input wire logic [31:0] cp_rdata,
    input wire logic        cp_trap,
    input wire logic        cp_undefined,
    input wire logic [7:0]  hyp_region_selector
);
    localparam logic [7:0]  SEL_MASK = 8'((1 << $clog2(HYP_REGIONS)) - 1);
    localparam logic [13:0] SEL_ENC  = {HSEL_OPC1, HSEL_CRN, HSEL_CRM, HSEL_OPC2};
    localparam logic [13:0] TYPE_ENC = {TYPE_OPC1, TYPE_CRN, TYPE_CRM, TYPE_OPC2};
    localparam logic [13:0] BASE_ENC = {BASE_OPC1, BASE_CRN, BASE_CRM, BASE_OPC2};
    wire logic [13:0] enc = {cp_opc1, cp_crn, cp_crm, cp_opc2};
    wire logic        sys = cp_req && cp_coproc == COPROC_SYS;
    wire logic        hyp = sys && cp_level == LEVEL_HYP;
    // Kernel accesses that reach the trap decision at all
    wire logic        knl = sys && cp_level == LEVEL_KERNEL && HYP_IMPLEMENTED
                            && !trap_general_exceptions_control;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    chk_done_follows: assert property (cp_req |=> cp_done) else $error("request unanswered");
    chk_no_stray: assert property (!cp_req |=> !cp_done && !cp_trap && !cp_undefined)
        else $error("answer without request");
    chk_user_refused: assert property (cp_req && cp_level == LEVEL_USER |=> cp_undefined)
        else $error("user access not refused");
    chk_sel_write: assert property (hyp && cp_write && enc == SEL_ENC |=>
        hyp_region_selector == ($past(cp_wdata[7:0]) & SEL_MASK)) else $error("selector wrong");
    chk_sel_trap: assert property (knl && enc == SEL_ENC && hyp_group_six_trap |=>
        cp_trap && $stable(hyp_region_selector)) else $error("selector trap missing");
    chk_type_value: assert property (hyp && !cp_write && enc == TYPE_ENC |=>
        cp_rdata == {16'h0, 8'(KERNEL_REGIONS), 8'h0}) else $error("type value wrong");
    chk_type_trap: assert property (knl && !cp_write && enc == TYPE_ENC &&
        (hyp_group_zero_trap || identification_group_one_trap) |=> cp_trap)
        else $error("type read trap missing");
    chk_base_wtrap: assert property (knl && cp_write && enc == BASE_ENC &&
        virtual_memory_write_trap |=> cp_trap) else $error("base write trap missing");
    chk_rdata_holds: assert property (!cp_req |=> $stable(cp_rdata)) else $error("rdata moved");
    cov_sel_write: cover property (hyp && cp_write && enc == SEL_ENC);
    cov_kernel_trap: cover property (cp_trap);
    cov_type_read: cover property (hyp && !cp_write && enc == TYPE_ENC);
endmodule : region_access_checker

bind mpu_region_select_base_regs region_access_checker #(.KERNEL_REGIONS(KERNEL_REGIONS),
    .HYP_REGIONS(HYP_REGIONS), .HYP_IMPLEMENTED(HYP_IMPLEMENTED)) chk (.mclk(mclk),
    .reset(reset), .cp_req(cp_req), .cp_write(cp_write), .cp_coproc(cp_coproc),
    .cp_opc1(cp_opc1), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_opc2(cp_opc2),
    .cp_wdata(cp_wdata), .cp_level(cp_level),
    .trap_general_exceptions_control(trap_general_exceptions_control),
    .hyp_group_zero_trap(hyp_group_zero_trap), .hyp_group_six_trap(hyp_group_six_trap),
    .virtual_memory_write_trap(virtual_memory_write_trap),
    .identification_group_one_trap(identification_group_one_trap), .cp_done(cp_done),
    .cp_rdata(cp_rdata), .cp_trap(cp_trap), .cp_undefined(cp_undefined),
    .hyp_region_selector(hyp_region_selector));

// File: tb/mpu_region_select_base_regs_bench.sv
`timescale 1ns/1ns
module mpu_region_select_base_regs_bench;
    import mpu_regs_pkg::*;
    localparam logic [13:0] SEL = {HSEL_OPC1, HSEL_CRN, HSEL_CRM, HSEL_OPC2};
    localparam logic [13:0] TYP = {TYPE_OPC1, TYPE_CRN, TYPE_CRM, TYPE_OPC2};
    localparam logic [13:0] BAS = {BASE_OPC1, BASE_CRN, BASE_CRM, BASE_OPC2};
    localparam logic [2:0]  OK  = 3'h4;
    localparam logic [2:0]  TRP = 3'h6;
    localparam logic [2:0]  UND = 3'h5;
    logic         mclk, reset, cp_req, cp_write, cp_done, cp_trap, cp_undefined;
    logic [3:0]   cp_coproc;
    logic [13:0]  enc;
    logic [31:0]  cp_wdata, cp_rdata, wd;
    logic [1:0]   cp_level;
    logic [6:0]   traps;
    logic [7:0]   ksel, hsel;
    logic [511:0] words;
    int           errors, n_compared;
    // ----------------------------------------
    // Trap bits: 0 general, 1 grp0, 2 grp6, 3 grp10, 4 vm write, 5 vm read, 6 ident
    // ----------------------------------------
    mpu_region_select_base_regs dut (.mclk(mclk), .reset(reset), .cp_req(cp_req),
        .cp_write(cp_write), .cp_coproc(cp_coproc), .cp_opc1(enc[13:11]), .cp_crn(enc[10:7]),
        .cp_crm(enc[6:3]), .cp_opc2(enc[2:0]), .cp_wdata(cp_wdata), .cp_level(cp_level),
        .trap_general_exceptions_control(traps[0]), .hyp_group_zero_trap(traps[1]),
        .hyp_group_six_trap(traps[2]), .hyp_group_ten_trap(traps[3]),
        .virtual_memory_write_trap(traps[4]), .virtual_memory_read_trap(traps[5]),
        .identification_group_one_trap(traps[6]), .kernel_region_selector(ksel),
        .cp_done(cp_done), .cp_rdata(cp_rdata), .cp_trap(cp_trap),
        .cp_undefined(cp_undefined), .hyp_region_selector(hsel), .region_base_attr(words));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    function automatic logic [13:0] dir(input logic [4:0] n);
        return {2'b00, n[4], 4'h6, 1'b1, n[3:1], n[0], 2'b00};
    endfunction : dir
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Answer is checked 1 ns after the taking edge
    task automatic access(input logic wr, input logic [1:0] lvl, input logic [13:0] e,
                          input logic [31:0] d, input logic [2:0] resp);
        @(posedge mclk);
        #1;
        cp_req = 1'b1;
        cp_write = wr;
        cp_level = lvl;
        enc = e;
        cp_wdata = d;
        @(posedge mclk);
        #1;
        cp_req = 1'b0;
        check("response", {29'h0, resp}, {29'h0, cp_done, cp_trap, cp_undefined});
    endtask : access
    task automatic test_done;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    initial begin
        errors = 0;
        n_compared = 0;
        reset = 1'b1;
        cp_req = 1'b0;
        cp_write = 1'b0;
        cp_coproc = COPROC_SYS;
        enc = 14'h0;
        cp_wdata = 32'h0;
        cp_level = LEVEL_HYP;
        traps = 7'h00;
        ksel = 8'h00;
        repeat (12) @(posedge mclk);
        #1 reset = 1'b0;
        check("selector reset", 32'h0, {24'h0, hsel});
        check("words reset", 32'h0, {31'h0, |words});
        access(1'b1, LEVEL_HYP, SEL, 32'hFFFF_FF05, OK);
        check("selector", 32'h5, {24'h0, hsel});
        access(1'b1, LEVEL_HYP, SEL, 32'h0000_000F, OK);
        access(1'b0, LEVEL_HYP, SEL, 32'h0, OK);
        check("selector read", 32'h0000_000F, cp_rdata);
        access(1'b1, LEVEL_USER, SEL, 32'h1, UND);
        access(1'b1, LEVEL_KERNEL, SEL, 32'h1, UND);
        traps = 7'h04;
        access(1'b1, LEVEL_KERNEL, SEL, 32'h1, TRP);
        check("selector kept", 32'hF, {24'h0, hsel});
        traps = 7'h00;
        access(1'b1, LEVEL_KERNEL, TYP, 32'hFFFF_FFFF, OK);
        access(1'b0, LEVEL_KERNEL, TYP, 32'h0, OK);
        check("type", 32'h0000_1000, cp_rdata);
        access(1'b0, LEVEL_HYP, TYP, 32'h0, OK);
        check("type hyp", 32'h0000_1000, cp_rdata);
        access(1'b0, LEVEL_USER, TYP, 32'h0, UND);
        for (int t = 1; t < 7; t += 5) begin
            traps = 7'(1 << t);
            access(1'b0, LEVEL_KERNEL, TYP, 32'h0, TRP);
        end
        for (int n = 0; n < 16; n++) begin
            wd = {26'h2AA_AAAA ^ 26'(n), 1'b1, 5'(n * 5 + 1)};
            access(1'b1, LEVEL_HYP, dir(5'(n)), wd, OK);
            check("region word", {wd[31:6], 1'b0, wd[4:0]}, words[n*32 +: 32]);
            traps = 7'h00;
            access(1'b0, LEVEL_KERNEL, dir(5'(n)), 32'h0, OK);
            check("direct read", {wd[31:6], 1'b0, wd[4:0]}, cp_rdata);
        end
        access(1'b1, LEVEL_HYP, dir(5'd16), 32'h0, UND);
        ksel = 8'h07;
        access(1'b1, LEVEL_KERNEL, BAS, 32'hFFFF_FFFF, OK);
        check("indirect word", 32'hFFFF_FFDF, words[7*32 +: 32]);
        traps = 7'h10;
        access(1'b1, LEVEL_KERNEL, BAS, 32'h0, TRP);
        access(1'b0, LEVEL_KERNEL, BAS, 32'h0, OK);
        check("indirect read", 32'hFFFF_FFDF, cp_rdata);
        traps = 7'h20;
        access(1'b0, LEVEL_KERNEL, BAS, 32'h0, TRP);
        traps = 7'h04;
        access(1'b1, LEVEL_KERNEL, BAS, 32'h0, TRP);
        traps = 7'h08;
        access(1'b1, LEVEL_KERNEL, dir(5'd7), 32'h0, TRP);
        traps = 7'h7E;
        access(1'b1, LEVEL_HYP, BAS, 32'h0000_0040, OK);
        check("hyp write", 32'h0000_0040, words[7*32 +: 32]);
        traps = 7'h01;
        access(1'b0, LEVEL_KERNEL, BAS, 32'h0, UND);
        check("rdata kept", 32'hFFFF_FFDF, cp_rdata);
        ksel = 8'h10;
        access(1'b1, LEVEL_HYP, BAS, 32'h0000_0080, OK);
        check("no region word0", 32'hAAAA_AA81, words[0 +: 32]);
        check("no region word7", 32'h0000_0040, words[7*32 +: 32]);
        access(1'b0, LEVEL_HYP, BAS, 32'h0, OK);
        check("no region read", 32'h0, cp_rdata);
        ksel = 8'h07;
        traps = 7'h00;
        cp_coproc = 4'hE;
        access(1'b0, LEVEL_HYP, SEL, 32'h0, UND);
        cp_coproc = COPROC_SYS;
        access(1'b0, LEVEL_HYP, {SEL[13:3], 3'h2}, 32'h0, UND);
        test_done();
    end
endmodule : mpu_region_select_base_regs_bench
